// ==== rtl/tcc_defs.vh ====
// constants and field positions for the 16-bit timer capture/compare unit
//
// Behaviour
// - a capture coinciding with a register read wins; that read value is undefined.
// - reading the main counter never captures into the second register.
// - while stopped, both trigger pins give no edges; their level is tracked once run has been seen.
// - one-shot pulse works only in free-running and clear-on-trigger-edge modes.
// - first trigger used as count clock blocks captures triggered by it.
// - capture on count clock falling edge; interrupt on next rising edge.
// - registers in compare mode may suppress captures.
// - pin high after reset with rising edge selected gives an edge at first start.
// - restart after stop with pin high reports no rising edge.
// - count-clock filter samples main clock; capture filter samples count clock.
// - an edge is accepted only after two consecutive samples at the valid level.
// - first trigger valid edge is a two-bit field at bits 4 and 5.
// - counter runs when run-mode bits are nonzero; 00 means stopped.
`ifndef TCC_DEFS_VH
`define TCC_DEFS_VH
// ==========================================
// run modes (run_mode_bit_high, run_mode_bit_low)
`define TCC_MODE_STOP 2'h0
`define TCC_MODE_FREE 2'h1
`define TCC_MODE_CLR_EDGE 2'h2
`define TCC_MODE_CLR_MATCH 2'h3
// ==========================================
// prescaler mode register fields
`define TCC_PRM_ES_LO 4
`define TCC_PRM_ES_HI 5
`define TCC_PRM_CKS_LO 0
`define TCC_PRM_CKS_HI 1
`define TCC_CKS_EDGE 2'h3
// ==========================================
// valid edge codes
`define TCC_EDGE_FALL 2'h0
`define TCC_EDGE_RISE 2'h1
`define TCC_EDGE_BOTH 2'h3
// ==========================================
// reset values
`define TCC_CNT_RST 16'h0000
`define TCC_CCR_RST 16'h0000
`define TCC_RDATA_RST 16'h0000
`define TCC_PRE_W 8
`endif

// ==== rtl/tcc_edge_filt.v ====
// sampled noise filter and edge detector for one trigger pin
`timescale 1ns/1ps
module tcc_edge_filt (
  input wire clk_in,
  input wire rstn_in,
  input wire pin_in,
  input wire sample_in,
  input wire run_in,
  input wire [1:0] edge_sel_in,
  output reg edge_out
);
`include "tcc_defs.vh"
  reg s1_r;
  reg s2_r;
  reg lvl_r;
  reg primed_r;
  wire rise;
  wire fall;
  // ==========================================
  // filter: level accepted after two matching samples
  assign rise = s1_r & s2_r & ~lvl_r;
  assign fall = ~s1_r & ~s2_r & lvl_r;
  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      lvl_r <= 1'b0;
      primed_r <= 1'b0;
      edge_out <= 1'b0;
    end else begin
      edge_out <= 1'b0;
      if (!run_in) begin
        // stopped: pins ignored; level tracked only once run has been seen
        if (primed_r) begin
          lvl_r <= pin_in;
          s1_r <= pin_in;
          s2_r <= pin_in;
        end
      end else begin
        primed_r <= 1'b1; // lvl_r stays low until first start
        if (sample_in) begin
          s1_r <= pin_in;
          s2_r <= s1_r;
          if (rise || fall) begin
            lvl_r <= s1_r;
          end
          case (edge_sel_in)
            `TCC_EDGE_FALL: edge_out <= fall;
            `TCC_EDGE_RISE: edge_out <= rise;
            `TCC_EDGE_BOTH: edge_out <= rise | fall;
            default: edge_out <= 1'b0;
          endcase
        end
      end
    end
  end
endmodule

// ==== rtl/tcc_capcmp.v ====
// 16-bit timer/event counter capture and compare unit
`timescale 1ns/1ps
module tcc_capcmp #(
  parameter PRE_W = 8
) (
  input wire clk_in,
  input wire rstn_in,
  input wire trigger_input_first_in,
  input wire trigger_input_second_in,
  input wire run_mode_bit_low_in,
  input wire run_mode_bit_high_in,
  input wire [7:0] prescaler_mode_reg_in,
  input wire [1:0] second_edge_sel_in,
  input wire [1:0] ccr1_mode_in,
  input wire [1:0] ccr2_mode_in,
  input wire oneshot_en_in,
  input wire ccr1_wr_in,
  input wire ccr2_wr_in,
  input wire [15:0] wdata_in,
  input wire ccr1_rd_in,
  input wire ccr2_rd_in,
  input wire cnt_rd_in,
  output reg [15:0] main_counter_out,
  output reg [15:0] capcmp_reg_first_out,
  output reg [15:0] capcmp_reg_second_out,
  output reg [15:0] rdata_out,
  output reg capture_irq_first_out,
  output reg capture_irq_second_out,
  output reg match_irq_first_out,
  output reg match_irq_second_out,
  output reg overflow_out,
  output reg pulse_out
);
`include "tcc_defs.vh"
  // ccr mode field: bit0 = capture mode, bit1 = trigger source (0 second pin, 1 first pin)
  // ==========================================
  // reset and pin synchronisers
  reg rst_s1_r;
  reg rstn_r;
  reg t1_s1_r;
  reg t1_s2_r;
  reg t2_s1_r;
  reg t2_s2_r;
  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rst_s1_r <= 1'b0;
      rstn_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rstn_r <= rst_s1_r;
    end
  end
  always @(posedge clk_in or negedge rstn_r) begin
    if (!rstn_r) begin
      t1_s1_r <= 1'b0;
      t1_s2_r <= 1'b0;
      t2_s1_r <= 1'b0;
      t2_s2_r <= 1'b0;
    end else begin
      t1_s1_r <= trigger_input_first_in;
      t1_s2_r <= t1_s1_r;
      t2_s1_r <= trigger_input_second_in;
      t2_s2_r <= t2_s1_r;
    end
  end
  // ==========================================
  // run mode and count clock
  wire [1:0] mode = {run_mode_bit_high_in, run_mode_bit_low_in};
  wire run = (mode != `TCC_MODE_STOP);
  wire [1:0] cks = prescaler_mode_reg_in[`TCC_PRM_CKS_HI:`TCC_PRM_CKS_LO];
  wire [1:0] es1 = prescaler_mode_reg_in[`TCC_PRM_ES_HI:`TCC_PRM_ES_LO];
  wire edge_clk = (cks == `TCC_CKS_EDGE);
  reg [PRE_W-1:0] pre_r;
  reg cclk_r;
  wire cclk_rise;
  wire cclk_fall;
  // prescaled count clock as a half-duty wave; cks picks the divider tap
  always @(posedge clk_in or negedge rstn_r) begin
    if (!rstn_r) begin
      pre_r <= {PRE_W{1'b0}};
      cclk_r <= 1'b0;
    end else if (!run) begin
      pre_r <= {PRE_W{1'b0}};
      cclk_r <= 1'b0;
    end else begin
      pre_r <= pre_r + {{(PRE_W-1){1'b0}}, 1'b1};
      cclk_r <= pre_r[cks];
    end
  end
  assign cclk_rise = ~cclk_r & pre_r[cks] & run;
  assign cclk_fall = cclk_r & ~pre_r[cks] & run;
  // ==========================================
  // trigger filters: first pin sampled on main clock when it is the count clock
  wire e1;
  wire e2;
  wire samp1 = edge_clk ? 1'b1 : cclk_fall;
  tcc_edge_filt u_filt1 (
    .clk_in(clk_in),
    .rstn_in(rstn_r),
    .pin_in(t1_s2_r),
    .sample_in(samp1),
    .run_in(run),
    .edge_sel_in(es1),
    .edge_out(e1)
  );
  tcc_edge_filt u_filt2 (
    .clk_in(clk_in),
    .rstn_in(rstn_r),
    .pin_in(t2_s2_r),
    .sample_in(cclk_fall),
    .run_in(run),
    .edge_sel_in(second_edge_sel_in),
    .edge_out(e2)
  );
  // ==========================================
  // capture decisions; pin-1 edges cannot capture while clocking the counter
  wire e1_cap = e1 & ~edge_clk;
  wire tick = edge_clk ? e1 : cclk_rise;
  wire cap1_evt = ccr1_mode_in[0] & (ccr1_mode_in[1] ? e1_cap : e2);
  wire cap2_evt = ccr2_mode_in[0] & (ccr2_mode_in[1] ? e1_cap : e2);
  reg hit1_r;
  reg hit2_r;
  reg cap1_pend_r;
  reg cap2_pend_r;
  reg osp_r;
  // filtered edge lands a cycle after its sample point, so it waits for the next fall
  wire cap1 = ccr1_mode_in[0] & cclk_fall & (hit1_r | cap1_evt);
  wire cap2 = ccr2_mode_in[0] & cclk_fall & (hit2_r | cap2_evt);
  // ==========================================
  // counter, capture registers and interrupts
  always @(posedge clk_in or negedge rstn_r) begin
    if (!rstn_r) begin
      main_counter_out <= `TCC_CNT_RST;
      capcmp_reg_first_out <= `TCC_CCR_RST;
      capcmp_reg_second_out <= `TCC_CCR_RST;
      capture_irq_first_out <= 1'b0;
      capture_irq_second_out <= 1'b0;
      match_irq_first_out <= 1'b0;
      match_irq_second_out <= 1'b0;
      overflow_out <= 1'b0;
      cap1_pend_r <= 1'b0;
      cap2_pend_r <= 1'b0;
      osp_r <= 1'b0;
      pulse_out <= 1'b0;
      hit1_r <= 1'b0;
      hit2_r <= 1'b0;
      rdata_out <= `TCC_RDATA_RST;
    end else begin
      capture_irq_first_out <= 1'b0;
      capture_irq_second_out <= 1'b0;
      match_irq_first_out <= 1'b0;
      match_irq_second_out <= 1'b0;
      overflow_out <= 1'b0;
      // pending edge dropped when the register leaves capture mode, no stale capture
      hit1_r <= (hit1_r | cap1_evt) & ~cclk_fall & ccr1_mode_in[0];
      hit2_r <= (hit2_r | cap2_evt) & ~cclk_fall & ccr2_mode_in[0];
      // capture is taken on the falling count edge; capture beats write
      if (cap1) begin
        capcmp_reg_first_out <= main_counter_out;
        cap1_pend_r <= 1'b1;
      end else if (ccr1_wr_in) begin
        capcmp_reg_first_out <= wdata_in;
      end
      if (cap2) begin // counter reads never reach here
        capcmp_reg_second_out <= main_counter_out;
        cap2_pend_r <= 1'b1;
      end else if (ccr2_wr_in) begin
        capcmp_reg_second_out <= wdata_in;
      end
      // irq waits for the next rising count edge
      if (cclk_rise && cap1_pend_r && !cap1) begin
        capture_irq_first_out <= 1'b1;
        cap1_pend_r <= 1'b0;
      end
      if (cclk_rise && cap2_pend_r && !cap2) begin
        capture_irq_second_out <= 1'b1;
        cap2_pend_r <= 1'b0;
      end
      if (!run) begin
        main_counter_out <= `TCC_CNT_RST;
        osp_r <= 1'b0;
        pulse_out <= 1'b0;
        cap1_pend_r <= 1'b0;
        cap2_pend_r <= 1'b0;
        hit1_r <= 1'b0;
        hit2_r <= 1'b0;
      end else begin
        if (mode == `TCC_MODE_CLR_EDGE && e1 && !edge_clk) begin
          main_counter_out <= `TCC_CNT_RST;
        end else if (tick) begin
          if (mode == `TCC_MODE_CLR_MATCH && main_counter_out == capcmp_reg_first_out) begin
            main_counter_out <= `TCC_CNT_RST;
          end else begin
            main_counter_out <= main_counter_out + 16'h0001;
            overflow_out <= (main_counter_out == 16'hffff);
          end
          match_irq_first_out <= ~ccr1_mode_in[0] & (main_counter_out == capcmp_reg_first_out);
          match_irq_second_out <= ~ccr2_mode_in[0] & (main_counter_out == capcmp_reg_second_out);
        end
        // one-shot: armed by pin-1 edge, set on second match, cleared on first match
        if (oneshot_en_in && mode != `TCC_MODE_CLR_MATCH) begin
          if (e1 && !osp_r) begin
            osp_r <= 1'b1;
          end
          if (tick && osp_r && main_counter_out == capcmp_reg_second_out) begin
            pulse_out <= 1'b1;
          end
          if (tick && osp_r && main_counter_out == capcmp_reg_first_out) begin
            pulse_out <= 1'b0;
            osp_r <= 1'b0;
          end
        end else begin
          pulse_out <= 1'b0;
          osp_r <= 1'b0;
        end
      end
      // read data; undefined on collision, here the pre-capture value
      if (ccr1_rd_in) begin
        rdata_out <= capcmp_reg_first_out;
      end else if (ccr2_rd_in) begin
        rdata_out <= capcmp_reg_second_out;
      end else if (cnt_rd_in) begin
        rdata_out <= main_counter_out;
      end
    end
  end
endmodule

// ==== testbench/tcc_trig_src.sv ====
// trigger pin source model for the capture unit bench
`timescale 1ns/1ps
module tcc_trig_src (
  input wire clk_in,
  output logic pin1_out,
  output logic pin2_out
);
  // ==========
  // pin1 pulled high from reset on, pin2 low
  initial begin
    pin1_out = 1'b1;
    pin2_out = 1'b0;
  end
  // new level just after an edge, then held; real captures hold far past two count clocks
  task automatic drive(input bit sel, input logic lvl, input int hold);
    @(posedge clk_in);
    if (sel) pin2_out <= lvl;
    else pin1_out <= lvl;
    repeat (hold) @(posedge clk_in);
  endtask
endmodule

// ==== testbench/tcc_capcmp_chk.sv ====
// port assertions for the timer capture/compare unit
`timescale 1ns/1ps
module tcc_capcmp_chk (
  input wire clk_in,
  input wire rstn_in,
  input wire run_mode_bit_low_in,
  input wire run_mode_bit_high_in,
  input wire [7:0] prescaler_mode_reg_in,
  input wire [1:0] ccr1_mode_in,
  input wire [1:0] ccr2_mode_in,
  input wire ccr1_wr_in,
  input wire ccr2_wr_in,
  input wire [15:0] wdata_in,
  input wire ccr1_rd_in,
  input wire ccr2_rd_in,
  input wire cnt_rd_in,
  input wire [15:0] main_counter_out,
  input wire [15:0] capcmp_reg_first_out,
  input wire [15:0] capcmp_reg_second_out,
  input wire [15:0] rdata_out,
  input wire capture_irq_first_out,
  input wire capture_irq_second_out
);
  // ==========
  // helpers
  wire stop = !run_mode_bit_low_in && !run_mode_bit_high_in;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  a_cnt_read_data:
    assert property (cnt_rd_in && !ccr1_rd_in && !ccr2_rd_in && !ccr2_wr_in && !ccr2_mode_in[0] |=>
      rdata_out == $past(main_counter_out) && $stable(capcmp_reg_second_out))
    else $error("counter read wrong or disturbed second register");
  a_wr_ccr1_load:
    assert property (ccr1_wr_in && !ccr1_mode_in[0] |=> capcmp_reg_first_out == $past(wdata_in))
    else $error("first register write lost");
  a_cmp_no_cap:
    assert property (!ccr1_mode_in[0] && !ccr1_wr_in |=> $stable(capcmp_reg_first_out))
    else $error("compare register changed");
  a_stop_no_irq:
    assert property (stop[*8] |-> !capture_irq_first_out && !capture_irq_second_out)
    else $error("capture interrupt while stopped");
  a_cap_irq_follow:
    assert property (capcmp_reg_first_out != $past(capcmp_reg_first_out) && !$past(ccr1_wr_in)
      && !stop && !$past(stop) |-> ##[1:16] capture_irq_first_out)
    else $error("capture without later interrupt");
  a_pin1_clk_block:
    assert property (prescaler_mode_reg_in[1:0] == 2'h3 && ccr1_mode_in == 2'h3 && !ccr1_wr_in
      |=> $stable(capcmp_reg_first_out))
    else $error("capture on pin used as count clock");
  a_stop_cnt_hold:
    assert property (stop[*3] |=> $stable(main_counter_out))
    else $error("counter moved while stopped");
  a_free_cnt_runs:
    assert property ((!stop && !run_mode_bit_high_in && prescaler_mode_reg_in[1:0] == 2'h0)[*8]
      |-> main_counter_out != $past(main_counter_out, 7))
    else $error("counter not counting");
  // main scenarios reached
  c_irq_first: cover property (capture_irq_first_out);
  c_irq_second: cover property (capture_irq_second_out);
  c_cnt_read: cover property (cnt_rd_in);
endmodule

// ==== testbench/tcc_capcmp_tb.sv ====
// self-checking bench for the timer capture/compare unit
`timescale 1ns/1ps
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin fail_count++; \
  $display("[FAIL] %s exp %h got %h", n, e, a); end end
module tcc_capcmp_tb;
  logic clk, rstn, p1, p2, rl, rh, wr1, wr2, rd, rc, os, i1, i2, po, mi;
  logic [7:0] pmr;
  logic [1:0] s2, c1, c2;
  logic [15:0] wd, cnt, r1, r2, v, rdv;
  int fail_count = 0;
  int num_checks = 0;
  bit got;
  // ==========
  // design and pin source; second register read strobe left idle
  tcc_capcmp i_dut (.clk_in(clk), .rstn_in(rstn), .trigger_input_first_in(p1),
    .trigger_input_second_in(p2), .run_mode_bit_low_in(rl), .run_mode_bit_high_in(rh),
    .prescaler_mode_reg_in(pmr), .second_edge_sel_in(s2), .ccr1_mode_in(c1), .ccr2_mode_in(c2),
    .oneshot_en_in(os), .ccr1_wr_in(wr1), .ccr2_wr_in(wr2), .wdata_in(wd), .ccr1_rd_in(rc),
    .ccr2_rd_in(1'b0), .cnt_rd_in(rd), .main_counter_out(cnt), .capcmp_reg_first_out(r1),
    .capcmp_reg_second_out(r2), .rdata_out(rdv), .capture_irq_first_out(i1),
    .capture_irq_second_out(i2), .match_irq_first_out(mi), .match_irq_second_out(),
    .overflow_out(), .pulse_out(po));
  tcc_trig_src i_src (.clk_in(clk), .pin1_out(p1), .pin2_out(p2));
  // ==========
  // shared tasks
  task automatic run(input logic [1:0] m);
    @(posedge clk);
    {rh, rl} <= m;
  endtask
  // sample a bit after the edge so the registered pulse has landed
  task automatic see(input bit sel, input int n);
    got = 0;
    repeat (n) begin
      @(posedge clk);
      #1;
      if ((sel ? i2 : i1) === 1'b1) got = 1;
    end
  endtask
  task automatic end_of_test;
    if (fail_count == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // ==========
  // scenarios
  task automatic t_starts;
    run(2'h1);
    see(0, 200);
    `CHK("edge at first start", 1'b1, got)
    run(2'h0);
    repeat (10) @(posedge clk);
    run(2'h1);
    see(0, 200);
    `CHK("edge at restart", 1'b0, got)
  endtask
  task automatic t_stopped;
    run(2'h0);
    repeat (5) @(posedge clk);
    v = r1;
    i_src.drive(0, 0, 20);
    i_src.drive(0, 1, 20);
    see(0, 50);
    `CHK("irq while stopped", 1'b0, got)
    `CHK("reg while stopped", v, r1)
  endtask
  task automatic t_capture;
    run(2'h1);
    i_src.drive(1, 1, 0);
    see(1, 200);
    `CHK("second capture irq", 1'b1, got)
    v = r2;
    `CHK("second capture taken", 1'b1, v !== 16'h0)
    @(posedge clk) rd <= 1'b1;
    @(posedge clk) rd <= 1'b0;
    repeat (20) @(posedge clk);
    `CHK("second reg held", v, r2)
    i_src.drive(1, 0, 20);
    i_src.drive(1, 1, 0);
    i_src.drive(1, 0, 0);
    see(1, 100);
    `CHK("short pulse rejected", 1'b0, got)
  endtask
  task automatic t_pin1_clock;
    run(2'h0);
    @(posedge clk) pmr <= 8'h13;
    run(2'h1);
    repeat (5) @(posedge clk);
    v = r1;
    repeat (3) begin
      i_src.drive(0, 0, 20);
      i_src.drive(0, 1, 20);
    end
    `CHK("pin1 clock no capture", v, r1)
    `CHK("pin1 edges counted", 16'h0003, cnt)
  endtask
  task automatic t_compare;
    run(2'h0);
    @(posedge clk) begin
      pmr <= 8'h10;
      c1 <= 2'h2;
      wd <= 16'h1234;
      wr1 <= 1'b1;
    end
    @(posedge clk) wr1 <= 1'b0;
    run(2'h1);
    i_src.drive(0, 0, 20);
    i_src.drive(0, 1, 40);
    `CHK("compare reg kept", 16'h1234, r1)
    @(posedge clk) rc <= 1'b1;
    @(posedge clk) rc <= 1'b0;
    #1;
    `CHK("first reg read", 16'h1234, rdv)
  endtask
  // pulse from second to first compare value, counted in main clocks
  task automatic t_oneshot;
    int hi;
    int mc;
    hi = 0;
    mc = 0;
    run(2'h0);
    @(posedge clk) begin
      c2 <= 2'h0;
      wd <= 16'h0008;
      wr1 <= 1'b1;
    end
    @(posedge clk) begin
      wr1 <= 1'b0;
      wd <= 16'h0004;
      wr2 <= 1'b1;
    end
    @(posedge clk) begin
      wr2 <= 1'b0;
      os <= 1'b1;
    end
    run(2'h2);
    i_src.drive(0, 0, 20);
    i_src.drive(0, 1, 0);
    repeat (60) begin
      @(posedge clk);
      #1;
      if (po === 1'b1) hi++;
      if (mi === 1'b1) mc++;
    end
    `CHK("one-shot width", 8, hi)
    `CHK("first match irqs", 1, mc)
    @(posedge clk) rd <= 1'b1;
    #1;
    v = cnt;
    @(posedge clk) rd <= 1'b0;
    #1;
    `CHK("counter read data", v, rdv)
    run(2'h0);
    run(2'h3);
    hi = 0;
    i_src.drive(0, 0, 20);
    i_src.drive(0, 1, 0);
    repeat (60) begin
      @(posedge clk);
      #1;
      if (po !== 1'b0) hi++;
    end
    `CHK("no one-shot on match clear", 0, hi)
    @(posedge clk) os <= 1'b0;
  endtask
  // ==========
  // clock, reset and sequence
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    rstn = 1'b0;
    {rh, rl} = 2'h0;
    pmr = 8'h10;
    s2 = 2'h1;
    c1 = 2'h3;
    c2 = 2'h1;
    {wr1, wr2, rd, rc, os} = 5'h00;
    wd = 16'h0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    t_starts;
    t_stopped;
    t_capture;
    t_pin1_clock;
    t_compare;
    t_oneshot;
    end_of_test;
  end
  // hang guard, far beyond the roughly 1240 cycles the scenarios take
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    end_of_test;
  end
endmodule
bind tcc_capcmp tcc_capcmp_chk i_chk (.clk_in(clk_in), .rstn_in(rstn_in),
  .run_mode_bit_low_in(run_mode_bit_low_in), .run_mode_bit_high_in(run_mode_bit_high_in),
  .prescaler_mode_reg_in(prescaler_mode_reg_in), .ccr1_mode_in(ccr1_mode_in),
  .ccr2_mode_in(ccr2_mode_in), .ccr1_wr_in(ccr1_wr_in), .ccr2_wr_in(ccr2_wr_in),
  .wdata_in(wdata_in), .ccr1_rd_in(ccr1_rd_in), .ccr2_rd_in(ccr2_rd_in),
  .cnt_rd_in(cnt_rd_in), .main_counter_out(main_counter_out),
  .capcmp_reg_first_out(capcmp_reg_first_out), .capcmp_reg_second_out(capcmp_reg_second_out),
  .rdata_out(rdata_out), .capture_irq_first_out(capture_irq_first_out),
  .capture_irq_second_out(capture_irq_second_out));
